// file: logic/rail2_status_and_limits_bank.sv
// Rail-2 status flags and limit registers behind the management command port.
`include "rail2_status_map.svh"
`timescale 1ns/1ps
`default_nettype none
module rail2_status_and_limits_bank
    import rail2_status_pkg::*;
#(
    parameter int WDOG_W = 16,
    parameter logic [15:0] WDOG_LIMIT = `WDOG_LIMIT
)
(
    input wire logic clk, // 250 MHz clock.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic cmd_valid, // One-cycle command strobe.
    input wire logic cmd_write, // 1 = write or send-byte, 0 = read.
    input wire code_t cmd_code, // Command code.
    input wire word_t cmd_wdata, // Write data.
    output word_t rsp_data_ff, // Read data, valid with rsp_valid_ff.
    output logic rsp_valid_ff, // Answer strobe, one cycle after the command.
    output logic rsp_error_ff, // Command refused.
    input wire logic memory_busy_flag, // Nonvolatile memory busy.
    input wire logic protect_off, // A protection holds the rail off.
    input wire logic rail_enable, // Enable input level.
    input wire logic [7:0] target_voltage_code, // Target voltage code.
    input wire logic ovp_absolute, // Absolute over-voltage trip.
    input wire logic ovp_target, // Target-relative over-voltage trip.
    input wire logic sustained_current_protection, // Sustained over-current trip.
    input wire logic peak_current_protection, // Peak over-current trip.
    input wire logic output_undervoltage_flag, // Under-voltage protection trip.
    input wire logic uv_comparator, // Under-voltage comparator level.
    input wire logic output_ov_warning, // Output over-voltage warning.
    input wire logic output_uv_warning, // Output under-voltage warning.
    input wire logic output_oc_warning, // Output over-current warning.
    input wire logic input_undervoltage_flag, // Input under-voltage fault.
    input wire logic input_event, // Any input voltage, current or power event.
    input wire logic communication_fault_flag, // Bus communication fault.
    input wire logic second_sensor_otp, // Second sensor over-temperature trip.
    input wire logic ot_warning, // Over-temperature warning.
    input wire logic [7:0] sensed_temp, // Temperature, 1 C per count.
    input wire logic sensor_fault_enable, // Digital sense fault function enable.
    input wire logic merged_temp_mode, // Merged temperature mode selected.
    input wire logic fault_direction, // 1 = fault above threshold, 0 = below.
    input wire logic [5:0] sensor_fault_threshold, // Digital sense threshold.
    input wire logic [5:0] second_temp_sense_input, // Digitised sense voltage.
    input wire logic sense_limit_enable, // Sense-limit fault function enable.
    input wire logic sense_over_limit, // Sense voltage above its limit.
    input wire logic power_good, // Power-good level.
    input wire logic monitor_busy, // Monitor calculation running.
    input wire logic monitor_done, // Monitor calculation finished.
    input wire logic phase_redundancy_fault, // Phase redundancy event.
    input wire logic target_clamp_warning, // Target beyond max or min.
    input wire logic line_float, // Floating sense line detected.
    output logic hot_warning_flag_ff, // Hot warning flag.
    output logic rail_shutdown_ff, // Rail shut down by line float.
    output logic monitor_reset_ff, // Clears monitor value and timer.
    output logic [7:0] input_turn_on_threshold_ff, // Rising lockout threshold.
    output logic [7:0] input_turn_off_threshold_ff, // Falling lockout threshold.
    output logic [`SLEW_W-1:0] startup_ramp_rate_ff // Start-up ramp rate.
);

    // Set wins over clear so that no event is lost in the clearing cycle.
    function automatic latch_t sticky(input latch_t cur, input latch_t set, input logic clr);
        sticky = (cur & ~{`LT_N{clr}}) | set;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Command decode.

    logic rd_cmd, wr_cmd, clr_cmd, known_rd, known_wr;
    assign rd_cmd = cmd_valid && !cmd_write;
    assign wr_cmd = cmd_valid && cmd_write;
    assign clr_cmd = wr_cmd && (cmd_code == `CMD_CLEAR_FAULTS);
    always_comb
    begin
        known_rd = 1'b0;
        known_wr = 1'b0;
        unique case (cmd_code)
            `CMD_HOT_WARN, `CMD_IN_LOCKOUT, `CMD_STARTUP_SLEW:
            begin
                known_rd = 1'b1;
                known_wr = 1'b1;
            end
            `CMD_STATUS_BYTE, `CMD_STATUS_WORD, `CMD_OUTPUT_VOLTAGE_STATUS, `CMD_OUTPUT_CURRENT_STATUS:
                known_rd = 1'b1;
            `CMD_CLEAR_FAULTS:
                known_wr = 1'b1;
            default:
            begin
                known_rd = 1'b0;
                known_wr = 1'b0;
            end
        endcase
    end
    logic bad_cmd;
    assign bad_cmd = (rd_cmd && !known_rd) || (wr_cmd && !known_wr);

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers.

    word_t hot_cfg_ff, nxt_hot_cfg;
    logic [7:0] nxt_turn_on, nxt_turn_off;
    logic [`SLEW_W-1:0] nxt_ramp;
    logic nxt_hot_flag;
    always_comb
    begin
        nxt_hot_cfg = hot_cfg_ff;
        nxt_turn_on = input_turn_on_threshold_ff;
        nxt_turn_off = input_turn_off_threshold_ff;
        nxt_ramp = startup_ramp_rate_ff;
        if (wr_cmd && cmd_code == `CMD_HOT_WARN)
            nxt_hot_cfg = cmd_wdata;
        if (wr_cmd && cmd_code == `CMD_IN_LOCKOUT)
        begin
            nxt_turn_on = cmd_wdata[15:8];
            nxt_turn_off = cmd_wdata[7:0];
        end
        if (wr_cmd && cmd_code == `CMD_STARTUP_SLEW)
            nxt_ramp = cmd_wdata[`SLEW_W-1:0];
        nxt_hot_flag = hot_cfg_ff[`HOT_EN_BIT] && (sensed_temp > hot_cfg_ff[7:0]);
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hot_cfg_ff <= `RST_HOT_WARN;
            input_turn_on_threshold_ff <= 8'(`RST_IN_LOCKOUT >> 8);
            input_turn_off_threshold_ff <= 8'(`RST_IN_LOCKOUT);
            startup_ramp_rate_ff <= `RST_STARTUP_SLEW;
            hot_warning_flag_ff <= 1'b0;
        end
        else
        begin
            hot_cfg_ff <= nxt_hot_cfg;
            input_turn_on_threshold_ff <= nxt_turn_on;
            input_turn_off_threshold_ff <= nxt_turn_off;
            startup_ramp_rate_ff <= nxt_ramp;
            hot_warning_flag_ff <= nxt_hot_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Monitor watchdog: an overflow restarts the timer and the monitor value.

    logic [WDOG_W-1:0] wdog_ff, nxt_wdog;
    logic nxt_mon_reset, wdog_ovf;
    assign wdog_ovf = monitor_busy && (wdog_ff == WDOG_LIMIT[WDOG_W-1:0]);
    always_comb
    begin
        nxt_wdog = wdog_ff;
        if (wdog_ovf || monitor_done || !monitor_busy)
            nxt_wdog = '0;
        else
            nxt_wdog = wdog_ff + 1'b1;
        nxt_mon_reset = wdog_ovf;
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wdog_ff <= '0;
            monitor_reset_ff <= 1'b0;
        end
        else
        begin
            wdog_ff <= nxt_wdog;
            monitor_reset_ff <= nxt_mon_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Latched flags; a condition still present sets its flag again.

    latch_t latch_ff, nxt_latch, set_vec;
    logic sense_ff, nxt_sense, redund_ff, nxt_redund, nxt_shut;
    logic ov_any, oc_any, dig_fault;
    assign ov_any = ovp_absolute || ovp_target;
    assign oc_any = sustained_current_protection || peak_current_protection;
    always_comb
    begin
        dig_fault = 1'b0;
        if (sensor_fault_enable && merged_temp_mode)
        begin
            if (fault_direction)
                dig_fault = second_temp_sense_input > sensor_fault_threshold;
            else
                dig_fault = second_temp_sense_input < sensor_fault_threshold;
        end
    end
    always_comb
    begin
        set_vec = '0;
        set_vec[`LT_OV] = ov_any;
        set_vec[`LT_OC] = oc_any;
        set_vec[`LT_VINUV] = input_undervoltage_flag;
        set_vec[`LT_CML] = communication_fault_flag || bad_cmd;
        set_vec[`LT_TEMP] = second_sensor_otp || ot_warning;
        set_vec[`LT_TS2D] = dig_fault;
        set_vec[`LT_VOUT] = ov_any || output_undervoltage_flag
            || output_ov_warning || output_uv_warning;
        set_vec[`LT_IOUT] = oc_any || output_oc_warning;
        set_vec[`LT_INPUT] = input_event || input_undervoltage_flag;
        set_vec[`LT_WDOG] = wdog_ovf;
        set_vec[`LT_UVP] = output_undervoltage_flag;
        set_vec[`LT_CLAMP] = target_clamp_warning;
        set_vec[`LT_FLOAT] = line_float;
        set_vec[`LT_OCUV] = oc_any && uv_comparator;
        nxt_latch = sticky(latch_ff, set_vec, clr_cmd);
        nxt_sense = sense_ff || (sense_limit_enable && sense_over_limit);
        nxt_redund = redund_ff || phase_redundancy_fault;
        nxt_shut = nxt_latch[`LT_FLOAT];
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            latch_ff <= '0;
            sense_ff <= 1'b0;
            redund_ff <= 1'b0;
            rail_shutdown_ff <= 1'b0;
        end
        else
        begin
            latch_ff <= nxt_latch;
            sense_ff <= nxt_sense;
            redund_ff <= nxt_redund;
            rail_shutdown_ff <= nxt_shut;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status views and the read answer; reading a known code has no side effect.

    logic [7:0] byte_view, vout_view, iout_view;
    word_t word_view, rd_mux;
    logic rail_off;
    assign rail_off = protect_off || !rail_enable || (target_voltage_code == 8'h00)
        || rail_shutdown_ff;
    assign byte_view = {memory_busy_flag, rail_off, latch_ff[`LT_OV], latch_ff[`LT_OC],
        latch_ff[`LT_VINUV], latch_ff[`LT_TEMP], latch_ff[`LT_CML],
        latch_ff[`LT_TS2D]};
    assign word_view = {latch_ff[`LT_VOUT], latch_ff[`LT_IOUT], latch_ff[`LT_INPUT],
        sense_ff, !power_good, 2'b00, latch_ff[`LT_WDOG] || redund_ff,
        byte_view};
    assign vout_view = {latch_ff[`LT_OV], 2'b00, latch_ff[`LT_UVP], latch_ff[`LT_CLAMP],
        1'b0, latch_ff[`LT_FLOAT], 1'b0};
    assign iout_view = {latch_ff[`LT_OC], latch_ff[`LT_OCUV], 6'h00};
    always_comb
    begin
        unique case (cmd_code)
            `CMD_HOT_WARN: rd_mux = hot_cfg_ff;
            `CMD_IN_LOCKOUT: rd_mux = {input_turn_on_threshold_ff, input_turn_off_threshold_ff};
            `CMD_STARTUP_SLEW: rd_mux = {4'h0, startup_ramp_rate_ff};
            `CMD_STATUS_BYTE: rd_mux = {8'h00, byte_view};
            `CMD_STATUS_WORD: rd_mux = word_view;
            `CMD_OUTPUT_VOLTAGE_STATUS: rd_mux = {8'h00, vout_view};
            `CMD_OUTPUT_CURRENT_STATUS: rd_mux = {8'h00, iout_view};
            default: rd_mux = 16'h0000;
        endcase
    end
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rsp_valid_ff <= 1'b0;
            rsp_error_ff <= 1'b0;
            rsp_data_ff <= 16'h0000;
        end
        else
        begin
            rsp_valid_ff <= cmd_valid;
            rsp_error_ff <= bad_cmd;
            rsp_data_ff <= rd_cmd ? rd_mux : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks on the status bank.

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    a_hot_flag_cause: assert property (hot_cfg_ff[8] && sensed_temp > hot_cfg_ff[7:0]
        |=> hot_warning_flag_ff) else $error("hot warning missed");
    a_slew_top_zero: assert property (rd_cmd && cmd_code == `CMD_STARTUP_SLEW
        |=> rsp_data_ff[15:12] == 4'h0) else $error("slew top bits set");
    a_busy_live_read: assert property (rd_cmd && cmd_code == `CMD_STATUS_BYTE
        |=> rsp_data_ff[7] == $past(memory_busy_flag)) else $error("busy bit wrong");
    a_off_zero_code: assert property (rd_cmd && cmd_code == `CMD_STATUS_BYTE
        && target_voltage_code == 8'h00 |=> rsp_data_ff[6]) else $error("off bit low");
    a_clear_drops_ov: assert property (clr_cmd && !ov_any
        |=> !latch_ff[`LT_OV]) else $error("clear ignored");
    a_ov_holds: assert property (ov_any ##1 !clr_cmd
        |=> latch_ff[`LT_OV]) else $error("ov flag lost");
    a_oc_latch: assert property (oc_any |=> latch_ff[`LT_OC] && latch_ff[`LT_IOUT])
        else $error("oc flag missed");
    a_low_byte_same: assert property (rd_cmd && cmd_code == `CMD_STATUS_WORD
        |=> rsp_data_ff[7:0] == $past(byte_view)) else $error("word low byte differs");
    a_sense_sticky: assert property (sense_ff |=> sense_ff)
        else $error("sense fault cleared");
    a_reserved_zero: assert property (rd_cmd && cmd_code == `CMD_STATUS_WORD
        |=> rsp_data_ff[10:9] == 2'b00) else $error("reserved bits set");
    a_float_shuts: assert property (line_float |=> rail_shutdown_ff [*2] or clr_cmd)
        else $error("float did not shut rail");
    a_read_keeps: assert property (rd_cmd && set_vec == '0
        |=> latch_ff == $past(latch_ff)) else $error("read changed status");

    c_clear_faults: cover property (latch_ff != '0 ##1 clr_cmd ##1 latch_ff == '0);
    c_ocuv_seen: cover property (oc_any && uv_comparator ##1 latch_ff[`LT_OCUV]);
    c_wdog_ovf: cover property (wdog_ovf ##1 monitor_reset_ff);
    c_bad_cmd: cover property (bad_cmd ##1 rsp_error_ff);

endmodule
`default_nettype wire

// file: logic/rail2_status_map.svh
// Command codes, field positions, reset values and counts of the rail-2 status bank.
`ifndef RAIL2_STATUS_MAP_SVH
`define RAIL2_STATUS_MAP_SVH
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_HOT_WARN 8'h51
`define CMD_IN_LOCKOUT 8'h55
`define CMD_STARTUP_SLEW 8'h61
`define CMD_STATUS_BYTE 8'h78
`define CMD_STATUS_WORD 8'h79
`define CMD_OUTPUT_VOLTAGE_STATUS 8'h7A
`define CMD_OUTPUT_CURRENT_STATUS 8'h7B
`define HOT_EN_BIT 8
`define SLEW_W 12
`define RST_HOT_WARN 16'h0000
`define RST_IN_LOCKOUT 16'h0000
`define RST_STARTUP_SLEW 12'h000
`define WDOG_LIMIT 16'h0400
// Index of each latched flag inside the latch vector.
`define LT_OV 0
`define LT_OC 1
`define LT_VINUV 2
`define LT_TEMP 3
`define LT_CML 4
`define LT_TS2D 5
`define LT_VOUT 6
`define LT_IOUT 7
`define LT_INPUT 8
`define LT_WDOG 9
`define LT_UVP 10
`define LT_CLAMP 11
`define LT_FLOAT 12
`define LT_OCUV 13
`define LT_N 14
`endif

// file: logic/rail2_status_pkg.sv
// Types shared by the rail-2 status and limits bank.
package rail2_status_pkg;
    typedef logic [15:0] word_t;
    typedef logic [7:0] code_t;
    typedef logic [13:0] latch_t;
endpackage

// file: tb/rail2_host_model.sv
// Management bus host model that issues commands to the rail-2 status bank.
`timescale 1ns/1ps
`default_nettype none
module rail2_host_model
    import rail2_status_pkg::*;
(
    input wire logic clk, // Bank clock.
    output logic cmd_valid, // Command strobe.
    output logic cmd_write, // High for write or send-byte.
    output code_t cmd_code, // Command code.
    output word_t cmd_wdata // Write data.
);
    // The port is idle from time zero.
    initial {cmd_valid, cmd_write, cmd_code, cmd_wdata} = '0;

    // Drive one command at the falling edge; it is taken at the next rising edge.
    task automatic issue(input logic wr, input code_t code, input word_t data);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_code = code;
        cmd_wdata = data; // A clear-faults send-byte carries no data; the bench passes 0 here.
        @(posedge clk);
    endtask

    // Drop the strobe; stale data is inverted so it is never mistaken for a live word.
    task automatic idle();
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_wdata = ~cmd_wdata;
    endtask
endmodule
`default_nettype wire

// file: tb/test_rail2_status_and_limits_bank.sv
// Self-checking bench for the rail-2 status and limits bank.
`include "rail2_status_map.svh"
`timescale 1ns/1ps
`default_nettype none
module test_rail2_status_and_limits_bank
    import rail2_status_pkg::*;
;
    typedef struct packed {logic [27:0] m; code_t sb; code_t wh; code_t sv; code_t si;} ev_t;
    // Detector pulse, then status byte, word high byte, voltage and current status it leaves.
    ev_t tbl [17] = '{
        '{28'h0000008, 8'h20, 8'h80, 8'h80, 8'h00},
        '{28'h0000010, 8'h20, 8'h80, 8'h80, 8'h00},
        '{28'h0000020, 8'h10, 8'h40, 8'h00, 8'h80},
        '{28'h0000140, 8'h10, 8'h40, 8'h00, 8'hC0},
        '{28'h0000080, 8'h00, 8'h80, 8'h10, 8'h00},
        '{28'h0000200, 8'h00, 8'h80, 8'h00, 8'h00},
        '{28'h0000400, 8'h00, 8'h80, 8'h00, 8'h00},
        '{28'h0000800, 8'h00, 8'h40, 8'h00, 8'h00},
        '{28'h0001000, 8'h08, 8'h20, 8'h00, 8'h00},
        '{28'h0002000, 8'h00, 8'h20, 8'h00, 8'h00},
        '{28'h0004000, 8'h02, 8'h00, 8'h00, 8'h00},
        '{28'h0008000, 8'h04, 8'h00, 8'h00, 8'h00},
        '{28'h0010000, 8'h04, 8'h00, 8'h00, 8'h00},
        '{28'h00E0000, 8'h01, 8'h00, 8'h00, 8'h00},
        '{28'h00A0000, 8'h00, 8'h00, 8'h00, 8'h00},
        '{28'h4000000, 8'h00, 8'h00, 8'h08, 8'h00},
        '{28'h8000000, 8'h40, 8'h00, 8'h02, 8'h00}};
    logic [8:0] bad_list [5] = '{9'h003, 9'h178, 9'h17B, 9'h099, 9'h1FF};
    logic clk, resetn, cmd_valid, cmd_write, rsp_valid_ff, rsp_error_ff;
    logic hot_ff, shut_ff, mreset_ff;
    logic [27:0] d;
    logic [7:0] on_ff, off_ff;
    logic [11:0] ramp_ff;
    logic [16:0] e;
    code_t cmd_code, tvc, temp;
    word_t cmd_wdata, rsp_data_ff, v, u;
    logic [16:0] exp_q[$];
    int bad_count, checks_done, pulses;

    ////////////////////////////////////////////////////////////////////////////////
    // The watchdog limit is cut to 8 so an overflow takes a handful of cycles.
    rail2_status_and_limits_bank #(.WDOG_W(16), .WDOG_LIMIT(16'h0008)) DUT (
        .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_data_ff(rsp_data_ff),
        .rsp_valid_ff(rsp_valid_ff), .rsp_error_ff(rsp_error_ff),
        .memory_busy_flag(d[0]), .protect_off(d[1]), .rail_enable(d[2]),
        .target_voltage_code(tvc), .ovp_absolute(d[3]), .ovp_target(d[4]),
        .sustained_current_protection(d[5]), .peak_current_protection(d[6]),
        .output_undervoltage_flag(d[7]), .uv_comparator(d[8]), .output_ov_warning(d[9]),
        .output_uv_warning(d[10]), .output_oc_warning(d[11]),
        .input_undervoltage_flag(d[12]), .input_event(d[13]),
        .communication_fault_flag(d[14]), .second_sensor_otp(d[15]), .ot_warning(d[16]),
        .sensed_temp(temp), .sensor_fault_enable(d[17]), .merged_temp_mode(d[18]),
        .fault_direction(d[19]), .sensor_fault_threshold(6'h20),
        .second_temp_sense_input(6'h21), .sense_limit_enable(d[20]),
        .sense_over_limit(d[21]), .power_good(d[22]), .monitor_busy(d[23]),
        .monitor_done(d[24]), .phase_redundancy_fault(d[25]),
        .target_clamp_warning(d[26]), .line_float(d[27]), .hot_warning_flag_ff(hot_ff),
        .rail_shutdown_ff(shut_ff), .monitor_reset_ff(mreset_ff),
        .input_turn_on_threshold_ff(on_ff), .input_turn_off_threshold_ff(off_ff),
        .startup_ramp_rate_ff(ramp_ff)
    );
    rail2_host_model host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));

    // Free-running 250 MHz clock and a count of monitor reset pulses.
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) if (mreset_ff === 1'b1) pulses++;

    // Compare one value and count the comparison.
    task automatic check(input string name, input word_t exp, input word_t got);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Note the expected answer, then have the host issue the command.
    task automatic tx(input logic wr, input code_t c, input word_t dat, input logic [16:0] x);
        exp_q.push_back(x);
        host.issue(wr, c, dat);
    endtask

    // Each answer is paired with the oldest note left by the driver.
    always @(negedge clk)
    begin
        if (rsp_valid_ff === 1'b1)
        begin
            if (exp_q.size() == 0)
                e = 17'h1DEAD;
            else
                e = exp_q.pop_front();
            check("rsp_data", e[15:0], rsp_data_ff);
            check("rsp_error", {15'h0000, e[16]}, {15'h0000, rsp_error_ff});
        end
    end

    // Print the verdict and end the run.
    task automatic close_out();
        if (bad_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // A hang is cut short well beyond the expected run length.
    initial
    begin
        #40000;
        bad_count++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: rail on, power good, target code nonzero.
    initial
    begin
        resetn = 1'b0;
        d = 28'h0400004;
        tvc = 8'h40;
        temp = 8'h00;
        void'($urandom(32'h21240719));
        repeat (12) @(negedge clk);
        resetn = 1'b1;
        tx(0, `CMD_HOT_WARN, 0, {1'b0, `RST_HOT_WARN});
        tx(0, `CMD_IN_LOCKOUT, 0, {1'b0, `RST_IN_LOCKOUT});
        for (int c = 8'h78; c < 8'h7C; c++) tx(0, code_t'(c), 0, 0);
        v = 16'($urandom);
        u = 16'($urandom);
        tx(1, `CMD_IN_LOCKOUT, v, 0);
        tx(1, `CMD_STARTUP_SLEW, u, 0);
        tx(0, `CMD_IN_LOCKOUT, 0, {1'b0, v});
        tx(0, `CMD_STARTUP_SLEW, 0, {5'h00, u[11:0]});
        host.idle();
        check("turn_on", {8'h00, v[15:8]}, {8'h00, on_ff});
        check("turn_off", {8'h00, v[7:0]}, {8'h00, off_ff});
        check("ramp", {4'h0, u[11:0]}, {4'h0, ramp_ff});
        // Hot warning above the limit, not at it, and not while disabled.
        v = {8'h01, 8'($urandom_range(254, 1))};
        tx(1, `CMD_HOT_WARN, v, 0);
        tx(0, `CMD_HOT_WARN, 0, {1'b0, v});
        for (int k = 0; k < 3; k++)
        begin
            if (k == 2)
                tx(1, `CMD_HOT_WARN, {8'h00, v[7:0]}, 0);
            host.idle();
            temp = v[7:0] + 8'(k != 1);
            repeat (2) @(negedge clk);
            check("hot_flag", {15'h0000, k == 0}, {15'h0000, hot_ff});
        end
        // Live bits follow their inputs and survive clear-faults.
        d[0] = 1'b1;
        tx(0, `CMD_STATUS_BYTE, 0, 17'h00080);
        tx(1, `CMD_CLEAR_FAULTS, 0, 0);
        tx(0, `CMD_STATUS_BYTE, 0, 17'h00080);
        host.idle();
        d[0] = 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            d[1] = (k == 0);
            d[2] = (k != 1);
            tvc = (k == 2) ? 8'h00 : 8'h40;
            tx(0, `CMD_STATUS_BYTE, 0, 17'h00040);
            host.idle();
        end
        tvc = 8'h40;
        d[22] = 1'b0;
        tx(0, `CMD_STATUS_WORD, 0, 17'h00800);
        host.idle();
        d[22] = 1'b1;
        // Each table entry in turn: one-cycle detector pulse, read, clear, read.
        foreach (tbl[i])
        begin
            d = d | tbl[i].m;
            @(negedge clk) d = d & ~tbl[i].m;
            check("shutdown", {15'h0000, tbl[i].m[27]}, {15'h0000, shut_ff});
            tx(0, `CMD_STATUS_BYTE, 0, {9'h000, tbl[i].sb});
            tx(0, `CMD_STATUS_WORD, 0, {1'b0, tbl[i].wh, tbl[i].sb});
            tx(0, `CMD_OUTPUT_VOLTAGE_STATUS, 0, {9'h000, tbl[i].sv});
            tx(0, `CMD_OUTPUT_CURRENT_STATUS, 0, {9'h000, tbl[i].si});
            tx(0, `CMD_STATUS_BYTE, 0, {9'h000, tbl[i].sb});
            tx(1, `CMD_CLEAR_FAULTS, 0, 0);
            for (int c = 8'h78; c < 8'h7C; c++) tx(0, code_t'(c), 0, 0);
            host.idle();
        end
        // Refused commands answer with an error and latch the communication flag.
        foreach (bad_list[i]) tx(bad_list[i][8], bad_list[i][7:0], 16'($urandom), 17'h10000);
        tx(0, `CMD_STATUS_BYTE, 0, 17'h00002);
        // A condition still present at clear-faults stays reported.
        host.idle();
        d[3] = 1'b1;
        tx(1, `CMD_CLEAR_FAULTS, 0, 0);
        tx(0, `CMD_STATUS_BYTE, 0, 17'h00020);
        host.idle();
        d[3] = 1'b0;
        tx(1, `CMD_CLEAR_FAULTS, 0, 0);
        tx(0, `CMD_STATUS_BYTE, 0, 17'h00000);
        host.idle();
        // Watchdog: a done restarts the count; a long busy run overflows once.
        d[23] = 1'b1;
        repeat (6) @(negedge clk);
        d[24] = 1'b1;
        @(negedge clk) d[24] = 1'b0;
        repeat (6) @(negedge clk);
        d[23] = 1'b0;
        check("wdog_quiet", 16'h0000, 16'(pulses));
        @(negedge clk) d[23] = 1'b1;
        repeat (12) @(negedge clk);
        d[23] = 1'b0;
        check("wdog_pulse", 16'h0001, 16'(pulses));
        tx(0, `CMD_STATUS_WORD, 0, 17'h00100);
        tx(1, `CMD_CLEAR_FAULTS, 0, 0);
        tx(0, `CMD_STATUS_WORD, 0, 17'h00000);
        host.idle();
        // Sense-limit and redundancy flags ignore clear-faults and only reset drops them.
        d = d | 28'h2300000;
        @(negedge clk) d = d & ~28'h2300000;
        tx(0, `CMD_STATUS_WORD, 0, 17'h01100);
        tx(1, `CMD_CLEAR_FAULTS, 0, 0);
        tx(0, `CMD_STATUS_WORD, 0, 17'h01100);
        host.idle();
        repeat (2) @(negedge clk);
        resetn = 1'b0;
        repeat (3) @(negedge clk);
        resetn = 1'b1;
        tx(0, `CMD_STATUS_WORD, 0, 17'h00000);
        host.idle();
        repeat (2) @(negedge clk);
        check("pending", 16'h0000, 16'(exp_q.size()));
        close_out();
    end
endmodule
`default_nettype wire
